//--- rtl/prs_in_mux.sv
// Input bench read selector with variant gating
`timescale 1ns/1ps
module prs_in_mux
    import prs_pkg::*;
(
    // Selection
    input  wire logic [4:0]       index,
    input  wire prs_pkg::prs_var_e variant,
    // Sources
    input  wire prs_pkg::prs_periph_s periph,
    // Result
    output logic [7:0]            value
);
    import prs_pkg::*;

    // Channel n high byte at 2n+1, low at 2n+2
    function automatic logic [7:0] cmp_byte(input logic [95:0] vals, input logic [4:0] idx);
        logic [3:0] pos;
        pos = 4'(idx - IN_CMP_FIRST);
        cmp_byte = vals[8*pos +: 8];
    endfunction

    always_comb begin
        value = 8'h00;
        case (index)
            // [RULE_03] stack pointer
            IN_SP_LEVEL:  value = periph.sp_level;
            // [RULE_05] status, pins, counters
            IN_CMP_FLAGS: value = (variant == PRS_VAR_NO_CMP) ? 8'h00 : periph.cmp_flags;
            IN_PA_PINS:   value = periph.pa_pins;
            IN_PB_PINS:   value = periph.pb_pins;
            IN_PC_PINS:   value = periph.pc_pins;
            IN_PHASE_CNT: value = periph.phase_cnt;
            IN_TMR_CNT:   value = periph.tmr_cnt;
            IN_TMR_FLAGS: value = periph.tmr_flags;
            default: begin
                // [RULE_04] comparator pairs per variant
                if (index >= IN_CMP_FIRST && index <= IN_CMP_LAST6) begin
                    // [RULE_15] absent channels read zero
                    if (variant == PRS_VAR_CMP6 ||
                        (variant == PRS_VAR_CMP4 && index <= IN_CMP_LAST4)) begin
                        value = cmp_byte(periph.cmp_values, index);
                    end
                end
            end
        endcase
    end
endmodule

//--- rtl/prs_top.sv
// Peripheral register spaces: input, configuration and output benches
//
// Notes on behaviour
// [RULE_01] Input bench: twenty 8-bit registers selected by index from zero.
// [RULE_02] RAM-from-input load copies the chosen input byte to the given RAM address.
// [RULE_03] Input index zero always returns the current stack pointer.
// [RULE_04] Indices 1-12 hold comparator channels, high byte 2n+1, low 2n+2.
// [RULE_05] Indices 13-19: comparator status, ports A-C, phase counter, timer count, status.
// [RULE_06] Twenty-one config slots; program load reads the byte within the current page.
// [RULE_07] Config-from-RAM load writes the slot with the byte at the RAM address.
// [RULE_08] Slot 0 interrupt mask, polarity, brown-out; slots 17, 18 priorities.
// [RULE_09] Slots 4, 13, 11 port directions; 12 port A alternates; 14 port B analog.
// [RULE_10] Slots 5-7 timer, 8-10 phase driver, 19-20 phase pulse width.
// [RULE_11] Slot 2 watchdog; 1, 3 comparator; 15 its prescaler; 16 conversion mode.
// [RULE_12] Output bench written from program byte or RAM byte by separate loads.
// [RULE_13] Out 0-4 ports, timer count, reload; 9 phase counter; 5-8 unused.
// [RULE_14] Timer reload takes effect only in timer pulse-width modulation mode.
// [RULE_15] Unused output writes ignored; absent input indices read zero, no side effects.
`timescale 1ns/1ps
module prs_top
    import prs_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 nrst,
    // Variant strap, steady after reset
    input  wire prs_pkg::prs_var_e    variant,
    // Load command from the core
    input  wire prs_pkg::prs_cmd_s    cmd,
    output logic                      cmd_done,
    // Memory data returned in the same cycle as the read request on mem
    input  wire logic [7:0]           ram_rdata,
    input  wire logic [7:0]           prog_rdata,
    input  wire logic [4:0]           page,
    output prs_pkg::prs_mem_s         mem,
    // Peripheral values
    input  wire prs_pkg::prs_periph_s periph,
    // Configuration slots toward peripherals
    output logic [7:0]                irq_mask_cfg,
    output logic [7:0]                cmp_cfg_one,
    output logic [7:0]                wdog_cfg,
    output logic [7:0]                cmp_cfg_two,
    output logic [7:0]                pa_dir_cfg,
    output logic [7:0]                tmr_mode_cfg,
    output logic [7:0]                tmr_presc_wave_cfg,
    output logic [7:0]                tmr_presc_cfg,
    output logic [7:0]                phase_drv_presc_cfg,
    output logic [7:0]                phase_drv_presc_wave_cfg,
    output logic [7:0]                phase_drv_mode_cfg,
    output logic [7:0]                pc_dir_cfg,
    output logic [7:0]                pa_altfn_cfg,
    output logic [7:0]                pb_dir_cfg,
    output logic [7:0]                pb_analog_sel_cfg,
    output logic [7:0]                cmp_presc_cfg,
    output logic [7:0]                cmp_adc_mode_cfg,
    output logic [7:0]                irq_prio_cfg_a,
    output logic [7:0]                irq_prio_cfg_b,
    output logic [7:0]                phase_pulse_width_a,
    output logic [7:0]                phase_pulse_width_b,
    // Output bench
    output logic [7:0]                pa_out,
    output logic [7:0]                pb_out,
    output logic [7:0]                pc_out,
    output logic [7:0]                tmr_reload_out,
    output prs_pkg::prs_load_s        load
);
    import prs_pkg::*;

    typedef enum logic [1:0] {
        PRS_ST_IDLE,
        PRS_ST_FETCH,
        PRS_ST_DONE
    } prs_state_e;

    typedef struct packed {
        prs_state_e  st;
        prs_op_e     op;
        logic [4:0]  index;
        logic [7:0]  ram_addr;
        // Packed so the whole state stays one flat vector
        logic [CFG_COUNT-1:0][7:0] cfg;
        logic [7:0]  pa;
        logic [7:0]  pb;
        logic [7:0]  pc;
        logic [7:0]  reload;
        prs_mem_s    mem;
        prs_load_s   load;
        logic        done;
    } prs_regs_s;

    prs_regs_s  r_q;
    prs_regs_s  r_d;
    logic [7:0] in_value;

    // [RULE_01] input bench selection
    prs_in_mux u_in_mux (
        .index   (r_q.index),
        .variant (variant),
        .periph  (periph),
        .value   (in_value)
    );

    // Program byte address inside the selected page
    function automatic logic [12:0] paged(input logic [4:0] pg, input logic [12:0] addr);
        paged = {pg, addr[7:0]};
    endfunction

    function automatic logic pwm_mode(input logic [7:0] mode);
        pwm_mode = (mode[TMR_MODE_LSB +: TMR_MODE_W] == TMR_MODE_PWM);
    endfunction

    always_comb begin
        logic [7:0] data;
        data = 8'h00;
        r_d = r_q;
        r_d.mem.ram_rd = 1'b0;
        r_d.mem.ram_wr = 1'b0;
        r_d.mem.prog_rd = 1'b0;
        r_d.load.tmr_cnt_load = 1'b0;
        r_d.load.tmr_rld_load = 1'b0;
        r_d.load.phase_cnt_load = 1'b0;
        r_d.done = 1'b0;
        case (r_q.st)
            PRS_ST_IDLE: begin
                if (cmd.valid && cmd.op != PRS_OP_NONE) begin
                    r_d.op = cmd.op;
                    r_d.index = cmd.index;
                    r_d.ram_addr = cmd.ram_addr;
                    r_d.mem.ram_addr = cmd.ram_addr;
                    r_d.mem.prog_addr = paged(page, cmd.prog_addr);
                    r_d.st = PRS_ST_FETCH;
                    case (cmd.op)
                        // [RULE_07] read RAM source
                        PRS_OP_CFG_FROM_RAM,
                        PRS_OP_OUT_FROM_RAM: r_d.mem.ram_rd = 1'b1;
                        // [RULE_06] read program byte in page
                        PRS_OP_CFG_FROM_PROG,
                        PRS_OP_OUT_FROM_PROG: r_d.mem.prog_rd = 1'b1;
                        default: ;
                    endcase
                end
            end
            PRS_ST_FETCH: begin
                r_d.st = PRS_ST_DONE;
                r_d.done = 1'b1;
                case (r_q.op)
                    // [RULE_02] input byte to RAM
                    PRS_OP_RAM_FROM_IN: begin
                        if (r_q.index < 5'(IN_COUNT)) begin
                            r_d.mem.ram_wr = 1'b1;
                            r_d.mem.ram_wdata = in_value;
                        end
                    end
                    PRS_OP_CFG_FROM_PROG,
                    PRS_OP_CFG_FROM_RAM: begin
                        data = (r_q.op == PRS_OP_CFG_FROM_RAM) ? ram_rdata : prog_rdata;
                        // [RULE_08] slot write by index
                        if (r_q.index < 5'(CFG_COUNT)) begin
                            r_d.cfg[r_q.index] = data;
                        end
                    end
                    PRS_OP_OUT_FROM_PROG,
                    PRS_OP_OUT_FROM_RAM: begin
                        // [RULE_12] either source feeds output bench
                        data = (r_q.op == PRS_OP_OUT_FROM_RAM) ? ram_rdata : prog_rdata;
                        r_d.load.load_value = data;
                        // [RULE_13] output index decode
                        case (r_q.index[3:0])
                            OUT_PA:        r_d.pa = data;
                            OUT_PB:        r_d.pb = data;
                            OUT_PC:        r_d.pc = data;
                            OUT_TMR_CNT:   r_d.load.tmr_cnt_load = 1'b1;
                            OUT_TMR_RLD: begin
                                // [RULE_14] reload only in pwm mode
                                if (pwm_mode(r_q.cfg[CFG_TMR_MODE])) begin
                                    r_d.reload = data;
                                    r_d.load.tmr_rld_load = 1'b1;
                                end
                            end
                            OUT_PHASE_CNT: r_d.load.phase_cnt_load = 1'b1;
                            // [RULE_15] unused indices ignored
                            default: ;
                        endcase
                        if (r_q.index[4]) begin
                            r_d.pa = r_q.pa;
                            r_d.pb = r_q.pb;
                            r_d.pc = r_q.pc;
                            r_d.reload = r_q.reload;
                            r_d.load.tmr_cnt_load = 1'b0;
                            r_d.load.tmr_rld_load = 1'b0;
                            r_d.load.phase_cnt_load = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
            PRS_ST_DONE: r_d.st = PRS_ST_IDLE;
            default: r_d.st = PRS_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_q.st <= PRS_ST_IDLE;
            r_q.op <= PRS_OP_NONE;
            r_q.index <= 5'h00;
            r_q.ram_addr <= 8'h00;
            for (int i = 0; i < CFG_COUNT; i++) begin
                r_q.cfg[i] <= CFG_RESET;
            end
            r_q.pa <= OUT_RESET;
            r_q.pb <= OUT_RESET;
            r_q.pc <= OUT_RESET;
            r_q.reload <= OUT_RESET;
            r_q.mem <= '0;
            r_q.load <= '0;
            r_q.done <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flip-flops
    assign cmd_done = r_q.done;
    assign mem = r_q.mem;
    assign load = r_q.load;
    assign pa_out = r_q.pa;
    assign pb_out = r_q.pb;
    assign pc_out = r_q.pc;
    assign tmr_reload_out = r_q.reload;
    // [RULE_08] interrupt slots
    assign irq_mask_cfg = r_q.cfg[CFG_IRQ_MASK];
    assign irq_prio_cfg_a = r_q.cfg[CFG_IRQ_PRIO_A];
    assign irq_prio_cfg_b = r_q.cfg[CFG_IRQ_PRIO_B];
    // [RULE_11] watchdog and comparator slots
    assign wdog_cfg = r_q.cfg[CFG_WDOG];
    assign cmp_cfg_one = r_q.cfg[CFG_CMP_ONE];
    assign cmp_cfg_two = r_q.cfg[CFG_CMP_TWO];
    assign cmp_presc_cfg = r_q.cfg[CFG_CMP_PRESC];
    assign cmp_adc_mode_cfg = r_q.cfg[CFG_CMP_ADC_MODE];
    // [RULE_09] port slots
    assign pa_dir_cfg = r_q.cfg[CFG_PA_DIR];
    assign pb_dir_cfg = r_q.cfg[CFG_PB_DIR];
    assign pc_dir_cfg = r_q.cfg[CFG_PC_DIR];
    assign pa_altfn_cfg = r_q.cfg[CFG_PA_ALTFN];
    assign pb_analog_sel_cfg = r_q.cfg[CFG_PB_ANALOG];
    // [RULE_10] timer and phase driver slots
    assign tmr_mode_cfg = r_q.cfg[CFG_TMR_MODE];
    assign tmr_presc_wave_cfg = r_q.cfg[CFG_TMR_PRESC_WV];
    assign tmr_presc_cfg = r_q.cfg[CFG_TMR_PRESC];
    assign phase_drv_presc_cfg = r_q.cfg[CFG_PHD_PRESC];
    assign phase_drv_presc_wave_cfg = r_q.cfg[CFG_PHD_PRESC_WV];
    assign phase_drv_mode_cfg = r_q.cfg[CFG_PHD_MODE];
    assign phase_pulse_width_a = r_q.cfg[CFG_PHASE_PW_A];
    assign phase_pulse_width_b = r_q.cfg[CFG_PHASE_PW_B];

endmodule

//--- shared/prs_pkg.sv
// Package for the peripheral register spaces: indices, layouts, command codes
package prs_pkg;

    // Bench sizes
    localparam int IN_COUNT  = 20;
    localparam int CFG_COUNT = 21;
    localparam int OUT_SPAN  = 10;

    // Input bench indices
    localparam logic [4:0] IN_SP_LEVEL   = 5'h00;
    localparam logic [4:0] IN_CMP_FIRST  = 5'h01;
    localparam logic [4:0] IN_CMP_LAST4  = 5'h08;
    localparam logic [4:0] IN_CMP_LAST6  = 5'h0C;
    localparam logic [4:0] IN_CMP_FLAGS  = 5'h0D;
    localparam logic [4:0] IN_PA_PINS    = 5'h0E;
    localparam logic [4:0] IN_PB_PINS    = 5'h0F;
    localparam logic [4:0] IN_PC_PINS    = 5'h10;
    localparam logic [4:0] IN_PHASE_CNT  = 5'h11;
    localparam logic [4:0] IN_TMR_CNT    = 5'h12;
    localparam logic [4:0] IN_TMR_FLAGS  = 5'h13;

    // Configuration slot indices
    localparam logic [4:0] CFG_IRQ_MASK      = 5'h00;
    localparam logic [4:0] CFG_CMP_ONE       = 5'h01;
    localparam logic [4:0] CFG_WDOG          = 5'h02;
    localparam logic [4:0] CFG_CMP_TWO       = 5'h03;
    localparam logic [4:0] CFG_PA_DIR        = 5'h04;
    localparam logic [4:0] CFG_TMR_MODE      = 5'h05;
    localparam logic [4:0] CFG_TMR_PRESC_WV  = 5'h06;
    localparam logic [4:0] CFG_TMR_PRESC     = 5'h07;
    localparam logic [4:0] CFG_PHD_PRESC     = 5'h08;
    localparam logic [4:0] CFG_PHD_PRESC_WV  = 5'h09;
    localparam logic [4:0] CFG_PHD_MODE      = 5'h0A;
    localparam logic [4:0] CFG_PC_DIR        = 5'h0B;
    localparam logic [4:0] CFG_PA_ALTFN      = 5'h0C;
    localparam logic [4:0] CFG_PB_DIR        = 5'h0D;
    localparam logic [4:0] CFG_PB_ANALOG     = 5'h0E;
    localparam logic [4:0] CFG_CMP_PRESC     = 5'h0F;
    localparam logic [4:0] CFG_CMP_ADC_MODE  = 5'h10;
    localparam logic [4:0] CFG_IRQ_PRIO_A    = 5'h11;
    localparam logic [4:0] CFG_IRQ_PRIO_B    = 5'h12;
    localparam logic [4:0] CFG_PHASE_PW_A    = 5'h13;
    localparam logic [4:0] CFG_PHASE_PW_B    = 5'h14;

    // Output bench indices
    localparam logic [3:0] OUT_PA        = 4'h0;
    localparam logic [3:0] OUT_PB        = 4'h1;
    localparam logic [3:0] OUT_PC        = 4'h2;
    localparam logic [3:0] OUT_TMR_CNT   = 4'h3;
    localparam logic [3:0] OUT_TMR_RLD   = 4'h4;
    localparam logic [3:0] OUT_PHASE_CNT = 4'h9;

    // Timer mode field: low bits of the timer mode slot
    localparam int          TMR_MODE_LSB = 0;
    localparam int          TMR_MODE_W   = 2;
    localparam logic [1:0]  TMR_MODE_PWM = 2'h1;

    // Reset values
    localparam logic [7:0]  CFG_RESET = 8'h00;
    localparam logic [7:0]  OUT_RESET = 8'h00;

    // Load instruction codes from the core
    typedef enum logic [2:0] {
        PRS_OP_NONE          = 3'h0,
        PRS_OP_RAM_FROM_IN   = 3'h1,
        PRS_OP_CFG_FROM_PROG = 3'h2,
        PRS_OP_CFG_FROM_RAM  = 3'h3,
        PRS_OP_OUT_FROM_PROG = 3'h4,
        PRS_OP_OUT_FROM_RAM  = 3'h5
    } prs_op_e;

    // Variants: channel count of the comparator
    typedef enum logic [1:0] {
        PRS_VAR_NO_CMP = 2'h0,
        PRS_VAR_CMP4   = 2'h1,
        PRS_VAR_CMP6   = 2'h2
    } prs_var_e;

    // Command from core
    typedef struct packed {
        logic       valid;
        prs_op_e    op;
        logic [4:0] index;
        logic [7:0] ram_addr;
        logic [12:0] prog_addr;
    } prs_cmd_s;

    // Values sampled from the peripherals
    typedef struct packed {
        logic [7:0]  sp_level;
        logic [95:0] cmp_values;
        logic [7:0]  cmp_flags;
        logic [7:0]  pa_pins;
        logic [7:0]  pb_pins;
        logic [7:0]  pc_pins;
        logic [7:0]  phase_cnt;
        logic [7:0]  tmr_cnt;
        logic [7:0]  tmr_flags;
    } prs_periph_s;

    // Memory access requests toward RAM and program memory
    typedef struct packed {
        logic        ram_rd;
        logic        ram_wr;
        logic [7:0]  ram_addr;
        logic [7:0]  ram_wdata;
        logic        prog_rd;
        logic [12:0] prog_addr;
    } prs_mem_s;

    // Output bench strobes: one-cycle load pulses with their value
    typedef struct packed {
        logic       tmr_cnt_load;
        logic       tmr_rld_load;
        logic       phase_cnt_load;
        logic [7:0] load_value;
    } prs_load_s;

endpackage

//--- test/prs_mem_model.sv
// RAM and program memory model answering the block's strobes
`timescale 1ns/1ps
module prs_mem_model
    import prs_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Requests and answers
    input  wire prs_pkg::prs_mem_s mem,
    output logic [7:0]             ram_rdata,
    output logic [7:0]             prog_rdata
);
    logic [7:0] ram [256];
    logic [7:0] prog_byte;
    // Inverted outside strobes so stale data never passes
    assign prog_byte  = mem.prog_addr[7:0] ^ {mem.prog_addr[12:8], 3'h5};
    assign prog_rdata = mem.prog_rd ? prog_byte : ~prog_byte;
    assign ram_rdata  = mem.ram_rd ? ram[mem.ram_addr] : ~ram[mem.ram_addr];
    always @(posedge clk) begin
        if (mem.ram_wr) begin
            ram[mem.ram_addr] <= mem.ram_wdata;
        end
    end
endmodule

//--- test/prs_top_sva.sv
// Assertion checker for the peripheral register spaces
`timescale 1ns/1ps
module prs_top_sva
    import prs_pkg::*;
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 nrst,
    // Command, memory and peripheral side
    input wire prs_pkg::prs_cmd_s    cmd,
    input wire logic                 cmd_done,
    input wire logic [7:0]           ram_rdata,
    input wire logic [4:0]           page,
    input wire prs_pkg::prs_mem_s    mem,
    input wire prs_pkg::prs_periph_s periph,
    // Watched registers
    input wire logic [7:0]           wdog_cfg,
    input wire logic [7:0]           irq_mask_cfg,
    input wire logic [7:0]           tmr_mode_cfg,
    input wire logic [7:0]           tmr_reload_out,
    input wire logic [7:0]           pa_out,
    input wire prs_pkg::prs_load_s   load
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_done_has_cause: assert property (cmd_done |->
        $past(cmd.valid, 2) && $past(cmd.op, 2) != PRS_OP_NONE)
        else $error("done without a taken command");
    a_read_then_done: assert property ((mem.ram_rd || mem.prog_rd) |=> cmd_done)
        else $error("memory read not followed by done");
    a_page_address: assert property (mem.prog_rd |->
        mem.prog_addr == {$past(page), $past(cmd.prog_addr[7:0])})
        else $error("program address outside current page");
    a_sp_copy_value: assert property (mem.ram_wr && $past(cmd.index, 2) == IN_SP_LEVEL |->
        mem.ram_wdata == $past(periph.sp_level))
        else $error("stack pointer copy wrong");
    a_ram_wr_source: assert property (mem.ram_wr |-> cmd_done &&
        $past(cmd.op, 2) == PRS_OP_RAM_FROM_IN &&
        $past(cmd.index, 2) < 5'h14 && mem.ram_addr == $past(cmd.ram_addr, 2))
        else $error("RAM write without valid input copy");
    a_wdog_from_ram: assert property (cmd_done && $past(cmd.op, 2) == PRS_OP_CFG_FROM_RAM &&
        $past(cmd.index, 2) == CFG_WDOG |-> wdog_cfg == $past(ram_rdata))
        else $error("watchdog slot not loaded from RAM byte");
    a_regs_quiet: assert property (!cmd_done |->
        $stable(irq_mask_cfg) && $stable(wdog_cfg) && $stable(pa_out))
        else $error("register changed outside a load");
    a_reload_gate: assert property ($changed(tmr_reload_out) |-> $past(tmr_mode_cfg[1:0]) == TMR_MODE_PWM)
        else $error("reload changed outside pulse mode");
    a_unused_out: assert property (cmd_done && $past(cmd.op, 2) == PRS_OP_OUT_FROM_RAM &&
        $past(cmd.index, 2) inside {[5'h05:5'h08]} |->
        !load.tmr_cnt_load && !load.tmr_rld_load && !load.phase_cnt_load && $stable(tmr_reload_out))
        else $error("unused output index had an effect");
    a_phase_load: assert property (load.phase_cnt_load |-> cmd_done && $past(cmd.index, 2) == 5'h09)
        else $error("phase counter load from wrong index");
endmodule

bind prs_top prs_top_sva u_sva (.clk(clk), .nrst(nrst), .cmd(cmd), .cmd_done(cmd_done), .ram_rdata(ram_rdata),
    .page(page), .mem(mem), .periph(periph), .wdog_cfg(wdog_cfg), .irq_mask_cfg(irq_mask_cfg),
    .tmr_mode_cfg(tmr_mode_cfg), .tmr_reload_out(tmr_reload_out), .pa_out(pa_out), .load(load));

//--- test/prs_top_tb.sv
// Testbench for the peripheral register spaces
`timescale 1ns/1ps
module prs_top_tb;
    import prs_pkg::*;
    logic        clk     = 1'b0;
    logic        nrst    = 1'b0;
    prs_var_e    variant = PRS_VAR_CMP6;
    prs_cmd_s    cmd     = '0;
    logic [4:0]  page    = 5'h00;
    prs_periph_s periph;
    logic        cmd_done;
    logic [7:0]  ram_rdata;
    logic [7:0]  prog_rdata;
    prs_mem_s    mem;
    logic [7:0]  cv [21];
    logic [7:0]  pa_out, pb_out, pc_out, tmr_reload_out;
    prs_load_s   load, seen_load;
    int          mismatches = 0;
    int          samples_checked = 0;
    logic [7:0]  e;

    always #50 clk = ~clk;

    prs_top dut (.clk(clk), .nrst(nrst), .variant(variant), .cmd(cmd), .cmd_done(cmd_done),
        .ram_rdata(ram_rdata), .prog_rdata(prog_rdata), .page(page), .mem(mem), .periph(periph),
        .irq_mask_cfg(cv[0]), .cmp_cfg_one(cv[1]), .wdog_cfg(cv[2]), .cmp_cfg_two(cv[3]), .pa_dir_cfg(cv[4]),
        .tmr_mode_cfg(cv[5]), .tmr_presc_wave_cfg(cv[6]), .tmr_presc_cfg(cv[7]), .phase_drv_presc_cfg(cv[8]),
        .phase_drv_presc_wave_cfg(cv[9]), .phase_drv_mode_cfg(cv[10]), .pc_dir_cfg(cv[11]),
        .pa_altfn_cfg(cv[12]), .pb_dir_cfg(cv[13]), .pb_analog_sel_cfg(cv[14]), .cmp_presc_cfg(cv[15]),
        .cmp_adc_mode_cfg(cv[16]), .irq_prio_cfg_a(cv[17]), .irq_prio_cfg_b(cv[18]),
        .phase_pulse_width_a(cv[19]), .phase_pulse_width_b(cv[20]), .pa_out(pa_out), .pb_out(pb_out),
        .pc_out(pc_out), .tmr_reload_out(tmr_reload_out), .load(load));
    prs_mem_model mm (.clk(clk), .mem(mem), .ram_rdata(ram_rdata), .prog_rdata(prog_rdata));

    function automatic logic [7:0] exp_in(input int i, input prs_var_e v);
        logic [7:0] t [7];
        t = '{8'hD1, 8'hE2, 8'hE3, 8'hE4, 8'h71, 8'h72, 8'h73};
        if (i == 0) return 8'h3C;
        if (i == 13 && v == PRS_VAR_NO_CMP) return 8'h00;
        if (i >= 13) return t[i-13];
        if (v == PRS_VAR_CMP6 || (v == PRS_VAR_CMP4 && i <= 8)) return 8'h90 + 8'(i - 1);
        return 8'h00;
    endfunction

    function automatic logic [7:0] prog_exp(input logic [12:0] a);
        return a[7:0] ^ {a[12:8], 3'h5};
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One load command; returns at the settled done cycle, pulses collected
    task automatic run(input prs_op_e op, input logic [4:0] idx, input logic [7:0] ra, input logic [12:0] pa);
        int n;
        @(posedge clk);
        cmd <= '{1'b1, op, idx, ra, pa};
        @(posedge clk);
        cmd.valid <= 1'b0;
        seen_load = '0;
        n = 0;
        do begin
            @(negedge clk);
            seen_load = seen_load | load;
            n++;
        end while (cmd_done !== 1'b1 && n < 6);
        check("cmd_done", {7'h00, cmd_done}, 8'h01);
    endtask

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        mismatches++;
        print_verdict();
    end

    initial begin
        periph = '{8'h3C, 96'h0, 8'hD1, 8'hE2, 8'hE3, 8'hE4, 8'h71, 8'h72, 8'h73};
        for (int k = 0; k < 12; k++) periph.cmp_values[8*k +: 8] = 8'h90 + 8'(k);
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        for (int i = 0; i < 21; i++) check("cfg_reset", cv[i], CFG_RESET);
        check("reload_reset", tmr_reload_out, OUT_RESET);
        // Input copies under every variant; index 20 must not write
        for (int v = 2; v >= 0; v--) begin
            @(posedge clk);
            variant <= prs_var_e'(v);
            for (int i = 0; i < (v == 2 ? 21 : 14); i++) begin
                mm.ram[8'h20 + i] = 8'h5A;
                run(PRS_OP_RAM_FROM_IN, 5'(i), 8'h20 + 8'(i), 13'h0000);
                e = (i == 20) ? 8'h5A : exp_in(i, prs_var_e'(v));
                @(negedge clk);
                check("in_copy", mm.ram[8'h20 + i], e);
            end
        end
        // Output bench from program and RAM
        run(PRS_OP_OUT_FROM_PROG, 5'h00, 8'h00, 13'h0011);
        check("pa_out", pa_out, prog_exp(13'h0011));
        mm.ram[8'h60] = 8'hC6;
        mm.ram[8'h61] = 8'hC7;
        run(PRS_OP_OUT_FROM_RAM, 5'h01, 8'h60, 13'h0000);
        check("pb_out", pb_out, 8'hC6);
        run(PRS_OP_OUT_FROM_RAM, 5'h02, 8'h61, 13'h0000);
        check("pc_out", pc_out, 8'hC7);
        run(PRS_OP_OUT_FROM_RAM, 5'h03, 8'h60, 13'h0000);
        check("tmr_cnt_pulse", 8'(seen_load[10:8]), 8'h04);
        check("load_value", load.load_value, 8'hC6);
        run(PRS_OP_OUT_FROM_RAM, 5'h09, 8'h61, 13'h0000);
        check("phase_pulse", 8'(seen_load[10:8]), 8'h01);
        check("load_value", load.load_value, 8'hC7);
        run(PRS_OP_OUT_FROM_RAM, 5'h04, 8'h61, 13'h0000);
        check("reload_refused", tmr_reload_out, OUT_RESET);
        for (int i = 5; i < 9; i++) begin
            run(i[0] ? PRS_OP_OUT_FROM_PROG : PRS_OP_OUT_FROM_RAM, 5'(i), 8'h60, 13'h0022);
            check("unused_pulse", 8'(seen_load[10:8]), 8'h00);
            check("unused_pa", pa_out, prog_exp(13'h0011));
            check("unused_pb", pb_out, 8'hC6);
        end
        // Every slot from RAM; slot 21 does not exist; slot 5 becomes pulse mode
        for (int i = 0; i < 22; i++) begin
            mm.ram[8'h40 + i] = 8'hA0 + 8'(i);
            run(PRS_OP_CFG_FROM_RAM, 5'(i), 8'h40 + 8'(i), 13'h0000);
        end
        for (int i = 0; i < 21; i++) begin
            check("cfg_ram", cv[i], 8'hA0 + 8'(i));
        end
        run(PRS_OP_OUT_FROM_RAM, 5'h04, 8'h61, 13'h0000);
        check("reload_taken", tmr_reload_out, 8'hC7);
        check("reload_pulse", 8'(seen_load[10:8]), 8'h02);
        // Every slot from program memory inside page 0x13
        @(posedge clk);
        page <= 5'h13;
        for (int i = 0; i < 21; i++) run(PRS_OP_CFG_FROM_PROG, 5'(i), 8'h00, 13'h1F30 + 13'(i));
        for (int i = 0; i < 21; i++) check("cfg_prog", cv[i], prog_exp({5'h13, 8'h30 + 8'(i)}));
        print_verdict();
    end
endmodule
